// File: logic/twe_pkg.sv
package twe_pkg;

    localparam int ADDR_W     = 11;
    localparam int DATA_W     = 8;
    localparam int PAGE_BYTES = 16;
    localparam int PAGE_COUNT = 128;
    localparam int OFS_W      = 4;

    // device address byte fields
    localparam int DEV_TYPE_HI = 7;
    localparam int DEV_TYPE_LO = 4;
    localparam int DEV_HI_MSB  = 3;
    localparam int DEV_HI_LSB  = 1;
    localparam int DEV_RW_BIT  = 0;

    // type code value is arbitrary
    localparam logic [3:0] DEV_TYPE_CODE = 4'h5;

    localparam logic [3:0] BITS_PER_BYTE = 4'h8;

    localparam int CLK_KHZ    = 25000;
    localparam int TWR_US     = 1000;
    localparam int TWR_CYCLES = (TWR_US * CLK_KHZ) / 1000;

    localparam logic [ADDR_W-1:0] ADDR_RESET = 11'h000;

    typedef enum logic [3:0] {
        st_idle,
        st_dev,
        st_dev_ack,
        st_waddr,
        st_waddr_ack,
        st_wdata,
        st_wdata_ack,
        st_rdata,
        st_rack,
        st_prog
    } twe_state_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } twe_word_t;

endpackage

// File: logic/twe_buf.sv
module twe_buf #(
    parameter int W = 19
) (
    input  wire logic         mclk,
    input  wire logic         rst,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);

    logic [W-1:0] mem [2];
    logic         wptr;
    logic         rptr;
    logic [1:0]   count;
    logic         push;
    logic         pop;

    assign in_ready  = (count != 2'h2);
    assign out_valid = (count != 2'h0);
    assign out_data  = mem[rptr];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_ff @(posedge mclk) begin
        if (push) begin
            mem[wptr] <= in_data;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            wptr  <= 1'h0;
            rptr  <= 1'h0;
            count <= 2'h0;
        end else begin
            if (push) begin
                wptr <= ~wptr;
            end
            if (pop) begin
                rptr <= ~rptr;
            end
            count <= count + {1'h0, push} - {1'h0, pop};
        end
    end

    chk_buf_holds_word:
    assert property (@(posedge mclk) disable iff (rst)
        out_valid && !out_ready |=> out_valid && $stable(out_data))
        else $error("buffer dropped a stalled word");

endmodule // twe_buf

// File: logic/twe_slave.sv
// Operation
// - sda fall during scl high is start
// - silent until start, start leaves standby
// - sda rise during scl high stops transfer
// - transmitter releases after eighth, receiver acks ninth
// - acknowledger releases sda after ninth clock
// - master nack on read: device releases sda
// - standby on stop, write end, mismatch, nack
// - array is 128 pages of 16 bytes
// - top four bits compared to type code
// - bits three to one give upper address; only write commands load them
// - bit zero one reads, zero writes
// - ack on type match, else nack and standby
// - byte write acks address and one data
// - write stop starts timed cycle, inputs ignored
// - one cycle programs up to 16 row bytes
// - up to fifteen more data bytes acked
// - only low four address bits increment, wrapping; reads step the full address
// - sample on scl rise, drive after fall
// - bytes msb first, ack slot after eight
// - write protect at stop skips programming
module twe_slave #(
    parameter int TWR_CYCLES = twe_pkg::TWR_CYCLES
) (
    input  wire logic                          mclk,
    input  wire logic                          rst,
    input  wire logic                          scl_pin,
    input  wire logic                          sda_pin_in,
    output logic                               sda_pin_out,
    output logic                               sda_pin_oe,
    input  wire logic                          wp_pin,
    output logic [twe_pkg::ADDR_W-1:0]         rd_addr,
    input  wire logic [twe_pkg::DATA_W-1:0]    rd_data,
    output logic                               prog_valid,
    input  wire logic                          prog_ready,
    output twe_pkg::twe_word_t                 prog_word,
    output logic                               busy
);

    logic [2:0]                       scl_sync;
    logic [2:0]                       sda_sync;
    logic [1:0]                       wp_sync;
    logic                             scl_rise;
    logic                             scl_fall;
    logic                             start_ev;
    logic                             stop_ev;
    logic                             sda_now;
    twe_pkg::twe_state_t              state;
    logic [3:0]                       cnt;
    logic [twe_pkg::DATA_W-1:0]       shreg;
    logic [twe_pkg::DATA_W-1:0]       tx;
    logic                             drive_low;
    logic [twe_pkg::ADDR_W-1:0]       addr;
    logic [twe_pkg::DATA_W-1:0]       page [twe_pkg::PAGE_BYTES];
    logic [twe_pkg::PAGE_BYTES-1:0]   mask;
    logic [4:0]                       drain_idx;
    logic [31:0]                      twr_cnt;
    logic                             twr_done;
    logic                             byte_done;
    logic                             type_ok;
    logic                             buf_in_valid;
    logic                             buf_in_ready;
    twe_pkg::twe_word_t               buf_in_word;
    logic [$bits(twe_pkg::twe_word_t)-1:0] buf_out_bits;

    function automatic logic is_recv(input twe_pkg::twe_state_t s);
        return s == twe_pkg::st_dev || s == twe_pkg::st_waddr || s == twe_pkg::st_wdata;
    endfunction

    // two flops then an edge stage on scl and sda, two flops only on wp
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            scl_sync <= 3'h7;
            sda_sync <= 3'h7;
            wp_sync  <= 2'h0;
        end else begin
            scl_sync <= {scl_sync[1:0], scl_pin};
            sda_sync <= {sda_sync[1:0], sda_pin_in};
            wp_sync  <= {wp_sync[0], wp_pin};
        end
    end

    assign sda_now  = sda_sync[1];
    assign scl_rise = scl_sync[1] && !scl_sync[2];
    assign scl_fall = !scl_sync[1] && scl_sync[2];
    assign start_ev = scl_sync[1] && scl_sync[2] && sda_sync[2] && !sda_sync[1];
    assign stop_ev  = scl_sync[1] && scl_sync[2] && !sda_sync[2] && sda_sync[1];
    assign byte_done = is_recv(state) && scl_fall && cnt == twe_pkg::BITS_PER_BYTE;
    assign type_ok  = shreg[twe_pkg::DEV_TYPE_HI:twe_pkg::DEV_TYPE_LO]
                      == twe_pkg::DEV_TYPE_CODE;
    assign twr_done = twr_cnt >= 32'(TWR_CYCLES - 1);

    assign sda_pin_out = 1'h0;
    assign sda_pin_oe  = drive_low;
    assign rd_addr     = addr;
    assign busy        = state == twe_pkg::st_prog;

    // bus protocol state machine
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state     <= twe_pkg::st_idle;
            cnt       <= 4'h0;
            shreg     <= 8'h00;
            tx        <= 8'h00;
            drive_low <= 1'h0;
        end else if (start_ev && state != twe_pkg::st_prog) begin
            state     <= twe_pkg::st_dev;
            cnt       <= 4'h0;
            drive_low <= 1'h0;
        end else if (stop_ev && state != twe_pkg::st_prog) begin
            drive_low <= 1'h0;
            if (state == twe_pkg::st_wdata && |mask && !wp_sync[1]) begin
                state <= twe_pkg::st_prog;
            end else begin
                state <= twe_pkg::st_idle;
            end
        end else begin
            unique case (state)
                twe_pkg::st_idle: begin
                    drive_low <= 1'h0;
                end
                twe_pkg::st_dev, twe_pkg::st_waddr, twe_pkg::st_wdata: begin
                    if (scl_rise) begin
                        shreg <= {shreg[6:0], sda_now};
                        cnt   <= cnt + 4'h1;
                    end else if (byte_done) begin
                        cnt <= 4'h0;
                        if (state == twe_pkg::st_dev && !type_ok) begin
                            state <= twe_pkg::st_idle;
                        end else begin
                            drive_low <= 1'h1;
                            unique case (state)
                                twe_pkg::st_dev:   state <= twe_pkg::st_dev_ack;
                                twe_pkg::st_waddr: state <= twe_pkg::st_waddr_ack;
                                default:           state <= twe_pkg::st_wdata_ack;
                            endcase
                        end
                    end
                end
                twe_pkg::st_dev_ack: begin
                    if (scl_fall) begin
                        cnt <= 4'h0;
                        if (shreg[twe_pkg::DEV_RW_BIT]) begin
                            state     <= twe_pkg::st_rdata;
                            drive_low <= ~rd_data[7];
                            tx        <= {rd_data[6:0], 1'h0};
                        end else begin
                            state     <= twe_pkg::st_waddr;
                            drive_low <= 1'h0;
                        end
                    end
                end
                twe_pkg::st_waddr_ack, twe_pkg::st_wdata_ack: begin
                    if (scl_fall) begin
                        state     <= twe_pkg::st_wdata;
                        drive_low <= 1'h0;
                    end
                end
                twe_pkg::st_rdata: begin
                    if (scl_rise) begin
                        cnt <= cnt + 4'h1;
                    end else if (scl_fall) begin
                        if (cnt == twe_pkg::BITS_PER_BYTE) begin
                            cnt       <= 4'h0;
                            drive_low <= 1'h0;
                            state     <= twe_pkg::st_rack;
                        end else begin
                            drive_low <= ~tx[7];
                            tx        <= {tx[6:0], 1'h0};
                        end
                    end
                end
                twe_pkg::st_rack: begin
                    if (scl_rise && sda_now) begin
                        state <= twe_pkg::st_idle;
                    end else if (scl_fall) begin
                        state     <= twe_pkg::st_rdata;
                        drive_low <= ~rd_data[7];
                        tx        <= {rd_data[6:0], 1'h0};
                    end
                end
                twe_pkg::st_prog: begin
                    drive_low <= 1'h0;
                    if (twr_done && drain_idx[4]) begin
                        state <= twe_pkg::st_idle;
                    end
                end
                default: begin
                    state     <= twe_pkg::st_idle;
                    drive_low <= 1'h0;
                end
            endcase
        end
    end

    // array address counter
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            addr <= twe_pkg::ADDR_RESET;
        end else if (state != twe_pkg::st_prog) begin
            if (byte_done && state == twe_pkg::st_dev && type_ok
                && !shreg[twe_pkg::DEV_RW_BIT]) begin
                addr[10:8] <= shreg[twe_pkg::DEV_HI_MSB:twe_pkg::DEV_HI_LSB];
            end else if (byte_done && state == twe_pkg::st_waddr) begin
                addr[7:0] <= shreg;
            end else if (byte_done && state == twe_pkg::st_wdata) begin
                addr[3:0] <= addr[3:0] + 4'h1;
            end else if (state == twe_pkg::st_rack && scl_rise && !sda_now) begin
                addr <= addr + 11'h001;
            end
        end
    end

    // page latch: one row of 16 bytes
    always_ff @(posedge mclk) begin
        if (byte_done && state == twe_pkg::st_wdata) begin
            page[addr[3:0]] <= shreg;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            mask <= 16'h0000;
        end else if (state == twe_pkg::st_prog) begin
            if (twr_done && drain_idx[4]) begin
                mask <= 16'h0000;
            end
        end else if (start_ev) begin
            mask <= 16'h0000;
        end else if (byte_done && state == twe_pkg::st_wdata) begin
            mask[addr[3:0]] <= 1'h1;
        end
    end

    // timed write cycle and page drain
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            twr_cnt   <= 32'h0000_0000;
            drain_idx <= 5'h00;
        end else if (state != twe_pkg::st_prog) begin
            twr_cnt   <= 32'h0000_0000;
            drain_idx <= 5'h00;
        end else begin
            if (!twr_done) begin
                twr_cnt <= twr_cnt + 32'h0000_0001;
            end
            if (!drain_idx[4] && (!mask[drain_idx[3:0]] || buf_in_ready)) begin
                drain_idx <= drain_idx + 5'h01;
            end
        end
    end

    assign buf_in_valid = state == twe_pkg::st_prog && !drain_idx[4] && mask[drain_idx[3:0]];
    assign buf_in_word  = '{addr: {addr[10:4], drain_idx[3:0]}, data: page[drain_idx[3:0]]};

    twe_buf #(
        .W ($bits(twe_pkg::twe_word_t))
    ) twe_buf_inst (
        .mclk      (mclk),
        .rst       (rst),
        .in_valid  (buf_in_valid),
        .in_ready  (buf_in_ready),
        .in_data   (buf_in_word),
        .out_valid (prog_valid),
        .out_ready (prog_ready),
        .out_data  (buf_out_bits)
    );

    assign prog_word = twe_pkg::twe_word_t'(buf_out_bits);

    chk_start_wakes_dev:
    assert property (@(posedge mclk) disable iff (rst)
        start_ev && state != twe_pkg::st_prog |=> state == twe_pkg::st_dev && !sda_pin_oe)
        else $error("start did not open a command");

    chk_idle_stays_silent:
    assert property (@(posedge mclk) disable iff (rst)
        state == twe_pkg::st_idle && $past(state) == twe_pkg::st_idle |-> !sda_pin_oe)
        else $error("standby drove sda");

    chk_stop_ends_xfer:
    assert property (@(posedge mclk) disable iff (rst)
        stop_ev && state inside {twe_pkg::st_dev, twe_pkg::st_waddr, twe_pkg::st_rdata}
        |=> state == twe_pkg::st_idle)
        else $error("stop did not return to standby");

    chk_ack_held_high:
    assert property (@(posedge mclk) disable iff (rst)
        state inside {twe_pkg::st_dev_ack, twe_pkg::st_waddr_ack, twe_pkg::st_wdata_ack}
        && !scl_fall |=> sda_pin_oe)
        else $error("ack not held through ninth clock");

    chk_ack_release:
    assert property (@(posedge mclk) disable iff (rst)
        state inside {twe_pkg::st_waddr_ack, twe_pkg::st_wdata_ack} && scl_fall
        && !start_ev && !stop_ev |=> !sda_pin_oe ##1 !sda_pin_oe)
        else $error("ack not released after ninth clock");

    chk_nack_release:
    assert property (@(posedge mclk) disable iff (rst)
        state == twe_pkg::st_rack && scl_rise && sda_now && !stop_ev
        |=> state == twe_pkg::st_idle && !sda_pin_oe)
        else $error("master nack did not release sda");

    chk_type_mismatch:
    assert property (@(posedge mclk) disable iff (rst)
        byte_done && state == twe_pkg::st_dev && !type_ok && !start_ev && !stop_ev
        |=> state == twe_pkg::st_idle && !sda_pin_oe)
        else $error("mismatched type code was acknowledged");

    chk_upper_addr:
    assert property (@(posedge mclk) disable iff (rst)
        byte_done && state == twe_pkg::st_dev && type_ok && !shreg[0]
        && !start_ev && !stop_ev |=> addr[10:8] == $past(shreg[3:1]))
        else $error("upper address bits not taken");

    chk_page_wrap:
    assert property (@(posedge mclk) disable iff (rst)
        byte_done && state == twe_pkg::st_wdata && !start_ev && !stop_ev
        |=> addr[10:4] == $past(addr[10:4])
        && addr[3:0] == 4'($past(addr[3:0]) + 4'h1))
        else $error("page address did not wrap in row");

    chk_prog_no_answer:
    assert property (@(posedge mclk) disable iff (rst)
        state == twe_pkg::st_prog |=> !sda_pin_oe)
        else $error("device answered during write cycle");

    chk_wp_blocks_prog:
    assert property (@(posedge mclk) disable iff (rst)
        stop_ev && wp_sync[1] && state == twe_pkg::st_wdata |=> state == twe_pkg::st_idle)
        else $error("write protect did not block programming");

    chk_prog_min_len:
    assert property (@(posedge mclk) disable iff (rst)
        $fell(busy) |-> $past(twr_cnt) >= 32'(TWR_CYCLES - 1))
        else $error("write cycle ended too early");

endmodule // twe_slave

// File: dv/twe_master.sv
module twe_master (
    input  wire logic mclk,
    input  wire logic sda_wire,
    output logic      scl,
    output logic      sda_oe
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        scl = 1'b1;
        sda_oe = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    // sda falls with scl high, also as repeated start
    task automatic start_cond();
        tick(1);
        sda_oe = 1'b0;
        tick(2);
        scl = 1'b1;
        tick(4);
        sda_oe = 1'b1;
        tick(4);
        scl = 1'b0;
    endtask

    task automatic stop_cond();
        tick(1);
        sda_oe = 1'b1;
        tick(2);
        scl = 1'b1;
        tick(4);
        sda_oe = 1'b0;
        tick(4);
    endtask

    // data changes while scl low, sampled mid high phase
    task automatic clk_bit(input logic b, output logic s);
        tick(2);
        sda_oe = ~b;
        tick(2);
        scl = 1'b1;
        tick(2);
        s = sda_wire;
        tick(2);
        scl = 1'b0;
    endtask

    // msb first, released for the ninth clock
    task automatic send_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            clk_bit(b[i], s);
        end
        clk_bit(1'b1, ack);
    endtask

    // nack high leaves sda released in the ninth clock
    task automatic recv_byte(input logic nack, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            clk_bit(1'b1, b[i]);
        end
        clk_bit(nack, s);
    endtask

    task automatic recover();
        logic s;
        start_cond();
        repeat (9) clk_bit(1'b1, s);
        start_cond();
        stop_cond();
    endtask
endmodule // twe_master

// File: dv/test_twe_slave.sv
`define CHK(what, exp, got) begin check_count++; if ((got) !== (exp)) begin miscompares++; \
    $display("[FAIL] %s exp %0h got %0h", what, exp, got); end end

module test_twe_slave;
    timeunit 1ns;
    timeprecision 100ps;

    localparam int TWR = 20;

    logic               mclk;
    logic               rst;
    logic               wp_pin;
    logic               prog_ready;
    logic               sda_pin_out;
    logic               sda_pin_oe;
    logic               prog_valid;
    logic               busy;
    logic               scl;
    logic               m_oe;
    logic               sda;
    logic [10:0]        rd_addr;
    logic [7:0]         rd_data;
    twe_pkg::twe_word_t prog_word;
    logic [7:0]         mem [2048];
    int                 check_count;
    int                 miscompares;

    // open drain wire with pull-up
    assign sda = (sda_pin_oe ? sda_pin_out : 1'b1) & ~m_oe;
    assign rd_data = mem[rd_addr];

    twe_master twe_master_inst (.mclk(mclk), .sda_wire(sda), .scl(scl), .sda_oe(m_oe));

    twe_slave #(.TWR_CYCLES(TWR)) twe_slave_inst (
        .mclk(mclk), .rst(rst), .scl_pin(scl), .sda_pin_in(sda),
        .sda_pin_out(sda_pin_out), .sda_pin_oe(sda_pin_oe), .wp_pin(wp_pin),
        .rd_addr(rd_addr), .rd_data(rd_data), .prog_valid(prog_valid),
        .prog_ready(prog_ready), .prog_word(prog_word), .busy(busy));

    always @(posedge mclk) begin
        if (prog_valid && prog_ready) begin
            mem[prog_word.addr] <= prog_word.data;
        end
    end

    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    function automatic logic [7:0] init_val(input logic [10:0] a);
        return a[7:0] ^ 8'h3C;
    endfunction

    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    task automatic end_sim();
        $display("checks %0d miscompares %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic wait_idle();
        int n;
        n = 0;
        while ((busy !== 1'b0 || prog_valid !== 1'b0) && n < 2000) begin
            tick(1);
            n++;
        end
        if (n >= 2000) begin
            miscompares++;
            $display("[FAIL] idle wait exp 0 got busy");
            end_sim();
        end
    endtask

    task automatic wr_head(input logic [10:0] a);
        logic k;
        twe_master_inst.start_cond();
        twe_master_inst.send_byte({twe_pkg::DEV_TYPE_CODE, a[10:8], 1'b0}, k);
        `CHK("dev ack", 1'b0, k)
        twe_master_inst.send_byte(a[7:0], k);
        `CHK("addr ack", 1'b0, k)
    endtask

    task automatic type_codes();
        logic k;
        for (int t = 0; t < 16; t++) begin
            twe_master_inst.start_cond();
            twe_master_inst.send_byte({4'(t), 4'h0}, k);
            `CHK("type ack", (4'(t) != twe_pkg::DEV_TYPE_CODE), k)
            twe_master_inst.send_byte(8'h00, k);
            `CHK("silent", (4'(t) != twe_pkg::DEV_TYPE_CODE), k)
            twe_master_inst.stop_cond();
            `CHK("no prog", 1'b0, busy)
        end
    endtask

    task automatic byte_write(input logic [10:0] a, input logic [7:0] d);
        logic k;
        wr_head(a);
        twe_master_inst.send_byte(d, k);
        `CHK("data ack", 1'b0, k)
        twe_master_inst.stop_cond();
        `CHK("busy", 1'b1, busy)
        wait_idle();
        `CHK("byte", d, mem[a])
    endtask

    task automatic page_stall();
        logic k;
        prog_ready = 1'b0;
        wr_head(11'h26E);
        // sixteen distinct offsets, no byte loaded twice
        for (int i = 0; i < 16; i++) begin
            twe_master_inst.send_byte(8'h80 + 8'(i), k);
            `CHK("page ack", 1'b0, k)
        end
        twe_master_inst.stop_cond();
        twe_master_inst.start_cond();
        twe_master_inst.send_byte({twe_pkg::DEV_TYPE_CODE, 4'h0}, k);
        `CHK("poll nack", 1'b1, k)
        twe_master_inst.stop_cond();
        tick(40);
        `CHK("held", 1'b1, prog_valid)
        `CHK("busy stall", 1'b1, busy)
        prog_ready = 1'b1;
        wait_idle();
        for (int i = 0; i < 16; i++) begin
            `CHK("page", 8'h80 + 8'(i), mem[{7'h26, 4'hE + 4'(i)}])
        end
        `CHK("row kept", init_val(11'h270), mem[11'h270])
    endtask

    task automatic read_seq();
        logic       k;
        logic [7:0] b;
        wr_head(11'h7FE);
        twe_master_inst.start_cond();
        twe_master_inst.send_byte({twe_pkg::DEV_TYPE_CODE, 4'h1}, k);
        `CHK("rd ack", 1'b0, k)
        for (int i = 0; i < 3; i++) begin
            twe_master_inst.recv_byte(i == 2, b);
            `CHK("rd data", init_val(11'h7FE + 11'(i)), b)
        end
        tick(4);
        `CHK("released", 1'b0, sda_pin_oe)
        twe_master_inst.stop_cond();
        `CHK("no prog", 1'b0, busy)
    endtask

    task automatic protect();
        logic k;
        wp_pin = 1'b1;
        wr_head(11'h123);
        twe_master_inst.send_byte(8'h5E, k);
        `CHK("wp ack", 1'b0, k)
        twe_master_inst.stop_cond();
        `CHK("wp busy", 1'b0, busy)
        tick(10);
        `CHK("wp word", 1'b0, prog_valid)
        `CHK("wp mem", init_val(11'h123), mem[11'h123])
        wp_pin = 1'b0;
    endtask

    task automatic recovery();
        wr_head(11'h300);
        twe_master_inst.recover();
        `CHK("rec busy", 1'b0, busy)
        byte_write(11'h300, 8'h9B);
    endtask

    initial begin
        rst = 1'b1;
        wp_pin = 1'b0;
        prog_ready = 1'b1;
        check_count = 0;
        miscompares = 0;
        for (int i = 0; i < 2048; i++) begin
            mem[i] = init_val(11'(i));
        end
        repeat (3) @(posedge mclk);
        #1;
        rst = 1'b0;
        tick(4);
        `CHK("idle oe", 1'b0, sda_pin_oe)
        type_codes();
        read_seq();
        byte_write(11'h5A3, 8'hC4);
        page_stall();
        protect();
        recovery();
        end_sim();
    end
endmodule // test_twe_slave
